//--- bench/cfg_host_model.sv
// Behavioural configuration host issuing single reads and writes
`default_nettype none
module cfg_host_model (
  // Clock
  input  wire logic        clk,
  // Configuration bus towards the register block
  output logic             cfg_rd,
  output logic             cfg_wr,
  output logic [5:0]       cfg_dw_addr,
  output logic [3:0]       cfg_be,
  output logic [31:0]      cfg_wdata,
  input  wire logic [31:0] cfg_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  // Idle bus at time zero
  initial begin
    cfg_rd = 1'h0;
    cfg_wr = 1'h0;
    cfg_dw_addr = 6'h3f;
    cfg_be = 4'h0;
    cfg_wdata = 32'h5a5a_5a5a;
  end
  // Idle edge, then one write strobe; released lines show the inverse
  task automatic wr(input logic [5:0] a, input logic [3:0] b, input logic [31:0] d);
    @(posedge clk);
    #1;
    cfg_dw_addr = a;
    cfg_be = b;
    cfg_wdata = d;
    cfg_wr = 1'h1;
    @(posedge clk);
    #1;
    cfg_wr = 1'h0;
    cfg_dw_addr = ~a;
    cfg_be = ~b;
    cfg_wdata = ~d;
  endtask
  // Idle edge, then one read strobe; data taken once the registered answer stands
  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    @(posedge clk);
    #1;
    cfg_dw_addr = a;
    cfg_rd = 1'h1;
    @(posedge clk);
    #1;
    cfg_rd = 1'h0;
    cfg_dw_addr = ~a;
    @(posedge clk);
    #1;
    d = cfg_rdata;
  endtask
endmodule
`default_nettype wire

//--- bench/pci_power_mgmt_capability_regs_tb_top.sv
// Self-checking bench for the power-management capability registers
`include "pm_cap_map.svh"
`default_nettype none
module pci_power_mgmt_capability_regs_tb_top import pm_cap_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  // Stimulus and observed signals
  logic        clk = 1'h0, rst_n = 1'h0, por_n = 1'h0, wake_event = 1'h0;
  logic        prog_wr = 1'h0, prog_d3cold = 1'h0, prog_wake_d2 = 1'h0, prog_d2 = 1'h0;
  logic        cfg_rd, cfg_wr, wake_n, func_reset;
  logic [5:0]  cfg_dw_addr;
  logic [3:0]  cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata, r;
  logic [1:0]  power_state;
  int          fail_count = 0, n_tests = 0;
  // 100 MHz clock
  always #5 clk = ~clk;
  cfg_host_model cfg_host_model_i (.clk(clk), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
    .cfg_dw_addr(cfg_dw_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata));
  pci_power_mgmt_capability_regs pci_power_mgmt_capability_regs_i (.clk(clk), .rst_n(rst_n),
    .por_n(por_n), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_dw_addr(cfg_dw_addr), .cfg_be(cfg_be),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .prog_wr(prog_wr), .prog_d3cold(prog_d3cold),
    .prog_wake_d2(prog_wake_d2), .prog_d2(prog_d2), .wake_event(wake_event), .wake_n(wake_n),
    .func_reset(func_reset), .power_state(power_state));
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Read one dword and compare
  task automatic rdc(input string nm, input logic [5:0] a, input logic [31:0] e);
    cfg_host_model_i.rd(a, r);
    chk(nm, r, e);
  endtask
  // Load the capability programming bits
  task automatic prog(input logic c, input logic w, input logic d);
    {prog_d3cold, prog_wake_d2, prog_d2} = {c, w, d};
    prog_wr = 1'h1;
    @(posedge clk);
    #1;
    prog_wr = 1'h0;
  endtask
  // One-cycle wake source, then one settling cycle
  task automatic wake_pulse;
    wake_event = 1'h1;
    @(posedge clk);
    #1;
    wake_event = 1'h0;
    @(posedge clk);
    #1;
  endtask
  // Counts and verdict
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    #100us;
    fail_count++;
    close_out();
  end
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    #1;
    {rst_n, por_n} = 2'h3;
    rdc("hdr", `PM_HDR_DW, 32'h6411_0001);
    rdc("csr", `PM_CSR_DW, 32'h0000_0000);
    rdc("unmapped", 6'h13, 32'h0000_0000);
    // Every programming combination shows in the fixed capability frame
    for (int i = 0; i < 8; i++) begin
      prog(i[2], i[1], i[0]);
      rdc("cap", `PM_HDR_DW, {i[2], 1'h1, i[1], 2'h0, i[0], 10'h011, 16'h0001});
    end
    // PCI reset leaves programming bits alone
    rst_n = 1'h0;
    @(posedge clk);
    #1;
    rst_n = 1'h1;
    rdc("cap kept", `PM_HDR_DW, 32'he411_0001);
    cfg_host_model_i.wr(`PM_CSR_DW, 4'h3, 32'hffff_ff02);
    chk("d2", {30'h0, power_state}, 32'h0000_0002);
    cfg_host_model_i.wr(`PM_CSR_DW, 4'h3, 32'hffff_ff03);
    rdc("csr d3", `PM_CSR_DW, 32'h0000_0103);
    cfg_host_model_i.wr(`PM_CSR_DW, 4'h1, 32'h0000_0001);
    chk("d1 ignored", {30'h0, power_state}, 32'h0000_0003);
    cfg_host_model_i.wr(`PM_CSR_DW, 4'h1, 32'h0000_0000);
    chk("func reset", {31'h0, func_reset}, 32'h0000_0001);
    rdc("csr kept", `PM_CSR_DW, 32'h0000_0100);
    chk("reset pulse", {31'h0, func_reset}, 32'h0000_0000);
    wake_pulse();
    chk("wake on", {31'h0, wake_n}, 32'h0000_0000);
    rdc("status", `PM_CSR_DW, 32'h0000_8100);
    cfg_host_model_i.wr(`PM_CSR_DW, 4'h2, 32'h0000_8100);
    @(posedge clk);
    #1;
    chk("wake clr", {31'h0, wake_n}, 32'h0000_0001);
    cfg_host_model_i.wr(`PM_CSR_DW, 4'h2, 32'h0000_0000);
    wake_pulse();
    chk("wake gated", {31'h0, wake_n}, 32'h0000_0001);
    rdc("status gated", `PM_CSR_DW, 32'h0000_8000);
    cfg_host_model_i.wr(`PM_CSR_DW, 4'h2, 32'h0000_0100);
    @(posedge clk);
    #1;
    chk("wake late", {31'h0, wake_n}, 32'h0000_0000);
    cfg_host_model_i.wr(`PM_CSR_DW, 4'h2, 32'h0000_8100);
    @(posedge clk);
    #1;
    chk("wake off", {31'h0, wake_n}, 32'h0000_0001);
    close_out();
  end
endmodule
`default_nettype wire

//--- rtl/pci_power_mgmt_capability_regs.sv
// Power-management capability registers of the link function
`include "pm_cap_map.svh"
`default_nettype none
module pci_power_mgmt_capability_regs
  import pm_cap_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Reset of programming bits, power-on only
  input  wire logic        por_n,
  // Configuration access, dword addressed
  input  wire logic        cfg_rd,
  input  wire logic        cfg_wr,
  input  wire logic [5:0]  cfg_dw_addr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic      [31:0] cfg_rdata,
  // Capability programming from the miscellaneous register
  input  wire logic        prog_wr,
  input  wire logic        prog_d3cold,
  input  wire logic        prog_wake_d2,
  input  wire logic        prog_d2,
  // Wake source and outputs
  input  wire logic        wake_event,
  output logic             wake_n,
  output logic             func_reset,
  output logic [1:0]       power_state
);

  // Programming bits, set to strap defaults only by power-on reset
  logic       prog_d3cold_reg;
  logic       prog_wake_d2_reg;
  logic       prog_d2_reg;
  // Control and status state
  logic       wake_status_reg;
  logic       wake_enable_reg;
  power_state_field_t pstate_reg;
  // Output flops
  logic [31:0] rdata_reg;
  logic        wake_n_reg;
  logic        func_reset_reg;

  // Decoded accesses
  wire         hit_hdr     = (cfg_dw_addr == `PM_HDR_DW);
  wire         hit_csr     = (cfg_dw_addr == `PM_CSR_DW);
  wire         wr_csr_lo   = cfg_wr && hit_csr && cfg_be[0];
  wire         wr_csr_hi   = cfg_wr && hit_csr && cfg_be[1];
  wire [1:0]   ps_wdata    = cfg_wdata[1:0];
  wire         ps_write_ok = wr_csr_lo && (ps_wdata != `PS_D1);
  wire         sts_clear   = wr_csr_hi && cfg_wdata[`CSR_STS_BIT];
  wire         enb_next    = wr_csr_hi ? cfg_wdata[`CSR_ENB_BIT] : wake_enable_reg;
  power_state_field_t  ps_next;
  assign ps_next = ps_write_ok ? power_state_field_t'(ps_wdata) : pstate_reg;
  // Leaving D3hot for D0 triggers the internal function reset
  wire         d3_exit     = (pstate_reg == PWR_D3HOT) && (ps_next == PWR_D0);
  // Status: set beats clear, set independent of enable
  wire         sts_next    = wake_event | (wake_status_reg & ~sts_clear);

  // Capabilities word assembly
  wire [15:0]  cap_word;
  assign cap_word = {prog_d3cold_reg,
                     1'b1,
                     prog_wake_d2_reg,
                     2'b00,
                     prog_d2_reg,
                     1'b0,
                     1'b0, 2'b00, 1'b0,
                     1'b1,
                     1'b0,
                     `CAP_VERSION};
  // Control and status word, unused bits zero
  wire [15:0]  csr_word = {wake_status_reg, 6'h00, wake_enable_reg,
                           6'h00, pstate_reg};
  // Header dword and CSR dword (extension upper half is zero)
  wire [31:0]  hdr_dword = {cap_word, `PM_NEXT_PTR, `PM_CAP_ID};
  wire [31:0]  csr_dword = {`EXT_RESET, csr_word};
  wire [31:0]  rd_mux    = hit_hdr ? hdr_dword : (hit_csr ? csr_dword : 32'h0000_0000);

  // Programming bits: only power-on reset touches them
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      prog_d3cold_reg  <= `PROG_D3COLD_RST;
      prog_wake_d2_reg <= `PROG_WAKE_D2_RST;
      prog_d2_reg      <= `PROG_D2_RST;
    end else if (prog_wr) begin
      prog_d3cold_reg  <= prog_d3cold;
      prog_wake_d2_reg <= prog_wake_d2;
      prog_d2_reg      <= prog_d2;
    end
  end

  // Control and status word; function reset never reaches it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_status_reg <= 1'b0;
      wake_enable_reg <= 1'b0;
      pstate_reg      <= PWR_D0;
    end else begin
      wake_status_reg <= sts_next;
      wake_enable_reg <= enb_next;
      pstate_reg      <= ps_next;
    end
  end

  // Output flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg      <= 32'h0000_0000;
      wake_n_reg     <= 1'b1;
      func_reset_reg <= 1'b0;
    end else begin
      rdata_reg      <= cfg_rd ? rd_mux : rdata_reg;
      wake_n_reg     <= ~(sts_next & enb_next);
      func_reset_reg <= d3_exit;
    end
  end

  assign cfg_rdata   = rdata_reg;
  assign wake_n      = wake_n_reg;
  assign func_reset  = func_reset_reg;
  assign power_state = pstate_reg;

  // Checks
  wake_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    !wake_n |-> (wake_status_reg && wake_enable_reg))
    else $error("wake asserted without status and enable");
  sts_sticky_a: assert property (@(posedge clk) disable iff (!rst_n)
    wake_event |=> wake_status_reg)
    else $error("wake status missed an event");
  sts_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    (sts_clear && !wake_event) |=> (!wake_status_reg && wake_n))
    else $error("status clear failed");
  d1_ignore_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_csr_lo && ps_wdata == `PS_D1) |=> $stable(pstate_reg))
    else $error("D1 write changed power state");
  state_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_csr_lo && ps_wdata != `PS_D1) |=> (pstate_reg == $past(ps_wdata)))
    else $error("power state write lost");
  func_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
    func_reset |-> ($past(pstate_reg) == PWR_D3HOT && pstate_reg == PWR_D0))
    else $error("function reset without D3hot exit");
  keep_enable_a: assert property (@(posedge clk) disable iff (!rst_n)
    func_reset |-> $stable(wake_enable_reg))
    else $error("function reset disturbed control word");
  cap_fixed_a: assert property (@(posedge clk) disable iff (!rst_n)
    (cap_word & 16'h5bff) == 16'h4011)
    else $error("fixed capability bits wrong");
  hdr_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg_rd && hit_hdr) |=> (cfg_rdata[15:0] == 16'h0001))
    else $error("capability header wrong");
  ext_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg_rd && hit_csr) |=> (cfg_rdata[31:16] == 16'h0000
                             && cfg_rdata[14:9] == 6'h00))
    else $error("extension or reserved bits nonzero");

  // Capability programming loads
  // D3cold wake bit follows its programming input
  cap_d3c_load_a: assert property (@(posedge clk) disable iff (!por_n)
    prog_wr |=> (cap_word[`CAP_D3COLD_BIT] == $past(prog_d3cold)))
    else $error("D3cold wake bit not loaded");

  // D2 wake mask bit follows its programming input
  cap_wd2_load_a: assert property (@(posedge clk) disable iff (!por_n)
    prog_wr |=> (cap_word[`CAP_WAKE_D2_BIT] == $past(prog_wake_d2)))
    else $error("D2 wake mask bit not loaded");

  // D2 capable bit follows its programming input
  cap_d2_load_a: assert property (@(posedge clk) disable iff (!por_n)
    prog_wr |=> (cap_word[`CAP_D2_BIT] == $past(prog_d2)))
    else $error("D2 capable bit not loaded");

  // Programming bits move only on a load, PCI reset or not
  prog_keep_a: assert property (@(posedge clk) disable iff (!por_n)
    !prog_wr |=> $stable({prog_d3cold_reg, prog_wake_d2_reg, prog_d2_reg}))
    else $error("programming bits changed without a load");

  // Capability read path
  // Fixed wake mask bits on the read bus
  mask_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg_rd && hit_hdr) |=> (cfg_rdata[30] && cfg_rdata[28:27] == 2'b00))
    else $error("fixed wake mask bits wrong");

  // D3cold wake bit as read
  d3cold_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg_rd && hit_hdr) |=> (cfg_rdata[31] == $past(prog_d3cold_reg)))
    else $error("D3cold wake bit read wrong");

  // D2 wake mask bit as read
  wake_d2_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg_rd && hit_hdr) |=> (cfg_rdata[29] == $past(prog_wake_d2_reg)))
    else $error("D2 wake mask bit read wrong");

  // D2 capable as programmed, D1 never
  d2_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg_rd && hit_hdr) |=> (cfg_rdata[26] == $past(prog_d2_reg) && !cfg_rdata[25]))
    else $error("state capability bits read wrong");

  // Dynamic data, init, clock and reserved bits read zero
  zero_fields_a: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg_rd && hit_hdr) |=> (cfg_rdata[24:21] == 4'h0 && !cfg_rdata[19]))
    else $error("zero capability fields read nonzero");

  // Auxiliary power flag reads one
  aux_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg_rd && hit_hdr) |=> cfg_rdata[16 + `CAP_AUX_BIT])
    else $error("auxiliary power flag read zero");

  // Version field reads its fixed code
  version_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg_rd && hit_hdr) |=> (cfg_rdata[18:16] == `CAP_VERSION))
    else $error("version field read wrong");

  // Control word
  // Whole control word as read
  csr_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg_rd && hit_csr) |=> (cfg_rdata[15:0] == {$past(wake_status_reg), 6'h00,
                             $past(wake_enable_reg), 6'h00, $past(pstate_reg)}))
    else $error("control word read wrong");

  // Unused control bits read zero
  csr_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg_rd && hit_csr) |=> (cfg_rdata[14:9] == 6'h00 && cfg_rdata[7:2] == 6'h00))
    else $error("unused control bits nonzero");

  // Enable takes the written bit
  enable_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr_csr_hi |=> (wake_enable_reg == $past(cfg_wdata[`CSR_ENB_BIT])))
    else $error("wake enable write lost");

  // Enable changes only by a write, function reset or not
  enable_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
    !wr_csr_hi |=> $stable(wake_enable_reg))
    else $error("wake enable changed without a write");

  // Power state changes only by a write
  state_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
    !wr_csr_lo |=> $stable(pstate_reg))
    else $error("power state changed without a write");

  // Function reset lasts one cycle
  reset_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
    func_reset |=> !func_reset)
    else $error("function reset longer than one cycle");

  // Leaving D3hot for D0 always fires the function reset
  d3_exit_fire_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_csr_lo && ps_wdata == `PS_D0 && pstate_reg == PWR_D3HOT) |=> func_reset)
    else $error("D3hot exit without function reset");

  // D2 write lands
  d2_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_csr_lo && ps_wdata == `PS_D2) |=> (power_state == `PS_D2))
    else $error("D2 write lost");

  // D3hot write lands
  d3_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_csr_lo && ps_wdata == `PS_D3HOT) |=> (power_state == `PS_D3HOT))
    else $error("D3hot write lost");

  // D0 write lands
  d0_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_csr_lo && ps_wdata == `PS_D0) |=> (power_state == `PS_D0))
    else $error("D0 write lost");

  // Wake output
  // Status and enable together drive the wake output
  wake_on_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wake_status_reg && wake_enable_reg) |-> !wake_n)
    else $error("wake output missing");

  // Cleared enable blocks the wake output
  enable_block_a: assert property (@(posedge clk) disable iff (!rst_n)
    !wake_enable_reg |-> wake_n)
    else $error("wake output while disabled");

  // Status is sticky until cleared
  status_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wake_status_reg && !sts_clear) |=> wake_status_reg)
    else $error("wake status lost");

  // Writing zero to the status bit has no effect
  zero_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_csr_hi && !cfg_wdata[`CSR_STS_BIT] && wake_status_reg) |=> wake_status_reg)
    else $error("zero write cleared wake status");

  // A new event wins over a clear in the same cycle
  set_wins_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wake_event && sts_clear) |=> wake_status_reg)
    else $error("clear beat a wake event");

endmodule
`default_nettype wire

//--- rtl/pm_cap_map.svh
// Offsets, field positions, reset values and fixed codes of the power-management block
`ifndef PM_CAP_MAP_SVH
`define PM_CAP_MAP_SVH
// Configuration dword offsets
`define PM_HDR_DW        6'h11
`define PM_CSR_DW        6'h12
// Byte offsets of the 16-bit words
`define PM_HDR_OFS       8'h44
`define PM_CAP_OFS       8'h46
`define PM_CSR_OFS       8'h48
`define PM_EXT_OFS       8'h4a
// Header codes
`define PM_CAP_ID        8'h01
`define PM_NEXT_PTR      8'h00
// Capabilities word fields
`define CAP_D3COLD_BIT   15
`define CAP_WAKE_D3H_BIT 14
`define CAP_WAKE_D2_BIT  13
`define CAP_WAKE_LO_HI   12
`define CAP_D2_BIT       10
`define CAP_AUX_BIT      4
`define CAP_VERSION      3'h1
`define CAP_RESET        16'h4001
// Control and status word fields
`define CSR_STS_BIT      15
`define CSR_ENB_BIT      8
`define CSR_RESET        16'h0000
`define EXT_RESET        16'h0000
// Power state codes
`define PS_D0            2'h0
`define PS_D1            2'h1
`define PS_D2            2'h2
`define PS_D3HOT         2'h3
// Strap defaults of the capability programming bits
`define PROG_D3COLD_RST  1'b0
`define PROG_WAKE_D2_RST 1'b1
`define PROG_D2_RST      1'b1
`endif

//--- rtl/pm_cap_pkg.sv
// Types shared by the power-management capability block
`default_nettype none
package pm_cap_pkg;
  // Device power state
  typedef enum logic [1:0] {
    PWR_D0    = 2'b00,
    PWR_D1    = 2'b01,
    PWR_D2    = 2'b10,
    PWR_D3HOT = 2'b11
  } power_state_field_t;
endpackage
`default_nettype wire
